// ### hpwg_bus_if.sv
// interface: parallel host port pins shared by host and device
`timescale 1ns/1ps
interface hpwg_bus_if;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic [6:0] addr;
    logic [15:0] data_h2d;
    logic [15:0] data_d2h;
    logic data_d2h_oe;
    modport host (output cs_n, output wr_n, output rd_n, output addr, output data_h2d,
        input data_d2h, input data_d2h_oe);
    modport device (input cs_n, input wr_n, input rd_n, input addr, input data_h2d,
        output data_d2h, output data_d2h_oe);
endinterface : hpwg_bus_if

// ### hpwg_device.sv
// device end: pad write strobe model, register file, status flags
// Operation
// - spurious write when cs falls, wr high
// - wr low outside cs arms spurious write
// - spurious write loads addressed register with data
// - dummy mode: host presets status or unused address
// - status write clears; unused address ignored
// - host holds dummy address through cs settling
// - enveloped read: wr low before cs envelopes cs
// - enveloped write commits on wr rising edge
`timescale 1ns/1ps
module hpwg_device
    import hpwg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    hpwg_bus_if.device bus,
    input wire logic [15:0] i_status_set,
    output logic [15:0] o_status_flags,
    output logic o_internal_write_pulse,
    output logic [6:0] o_write_addr,
    output logic [15:0] o_write_data
);
    // ====================================================
    // pin synchronisers (three stages, stages two and three compared)
    logic [2:0] cs_sync_reg;
    logic [2:0] wr_sync_reg;
    logic [2:0] rd_sync_reg;
    logic cs_n_reg;
    logic wr_n_reg;
    logic rd_n_reg;
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            cs_sync_reg <= 3'b111;
            wr_sync_reg <= 3'b111;
            rd_sync_reg <= 3'b111;
        end
        else
        begin
            cs_sync_reg <= {cs_sync_reg[1:0], bus.cs_n};
            wr_sync_reg <= {wr_sync_reg[1:0], bus.wr_n};
            rd_sync_reg <= {rd_sync_reg[1:0], bus.rd_n};
        end
    end
    wire cs_agree = cs_sync_reg[1] == cs_sync_reg[2];
    wire wr_agree = wr_sync_reg[1] == wr_sync_reg[2];
    wire rd_agree = rd_sync_reg[1] == rd_sync_reg[2];
    wire cs_n_next = cs_agree ? cs_sync_reg[2] : cs_n_reg;
    wire wr_n_next = wr_agree ? wr_sync_reg[2] : wr_n_reg;
    wire rd_n_next = rd_agree ? rd_sync_reg[2] : rd_n_reg;
    // ====================================================
    // pad strobe logic
    wire cs_fall = cs_n_reg & ~cs_n_next;
    wire wr_rise = ~wr_n_reg & wr_n_next;
    // flaw latch: set by wr low while deselected, cleared by any write
    logic armed_reg;
    wire stray_wr = ~wr_n_reg & cs_n_reg;
    wire spurious = cs_fall & wr_n_next & armed_reg;
    wire real_wr = wr_rise & ~cs_n_reg;
    wire any_wr = spurious | real_wr;
    logic armed_next;
    assign armed_next = stray_wr ? 1'b1 : (any_wr ? 1'b0 : armed_reg);
    // address and data are registered on every clock; host holds them stable
    logic [6:0] addr_q_reg;
    logic [15:0] data_q_reg;
    always_ff @(posedge i_clk)
    begin
        addr_q_reg <= bus.addr;
        data_q_reg <= bus.data_h2d;
    end
    // ====================================================
    // register file
    logic [15:0] regs_mem [0:NUM_REGS-1];
    logic [15:0] status_reg;
    wire hit_status = addr_q_reg == STATUS_FLAGS_ADDR;
    wire hit_used = (addr_q_reg < USED_REG_LIMIT) & ~hit_status;
    wire do_store = any_wr & hit_used;
    wire do_clear = any_wr & hit_status;
    // hardware set wins over the clear
    wire [15:0] status_next = do_clear ? i_status_set : (status_reg | i_status_set);
    always_ff @(posedge i_clk)
    begin
        if (do_store)
            regs_mem[addr_q_reg] <= data_q_reg;
    end
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            cs_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            rd_n_reg <= 1'b1;
            armed_reg <= 1'b0;
            status_reg <= STATUS_FLAGS_RESET;
            o_internal_write_pulse <= 1'b0;
            o_write_addr <= '0;
            o_write_data <= '0;
            bus.data_d2h <= '0;
            bus.data_d2h_oe <= 1'b0;
        end
        else
        begin
            cs_n_reg <= cs_n_next;
            wr_n_reg <= wr_n_next;
            rd_n_reg <= rd_n_next;
            armed_reg <= armed_next;
            status_reg <= status_next;
            o_internal_write_pulse <= any_wr;
            if (any_wr)
            begin
                o_write_addr <= addr_q_reg;
                o_write_data <= data_q_reg;
            end
            // unused addresses read zero
            bus.data_d2h <= hit_status ? status_reg : (hit_used ? regs_mem[addr_q_reg] : '0);
            bus.data_d2h_oe <= ~cs_n_reg & ~rd_n_reg;
        end
    end
    assign o_status_flags = status_reg;
endmodule : hpwg_device

// ### hpwg_host.sv
// host end: bus sequencer applying the chosen write guard method
`timescale 1ns/1ps
module hpwg_host
    import hpwg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    hpwg_bus_if.host bus,
    input wire logic i_mode_envelope,
    input wire logic i_req,
    input wire logic i_req_write,
    input wire logic [6:0] i_req_addr,
    input wire logic [15:0] i_req_data,
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_rdata
);
    typedef enum logic [2:0] {
        HS_IDLE, HS_PRESET, HS_SELECT, HS_STROBE, HS_RELEASE, HS_SETTLE
    } hpwg_hstate_type;
    hpwg_hstate_type state_reg;
    logic [3:0] cnt_reg;
    logic is_wr_reg;
    hpwg_mode_type mode_reg;
    logic [6:0] taddr_reg;
    wire cnt_done = cnt_reg == WAIT_RESET;
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            state_reg <= HS_IDLE;
            cnt_reg <= WAIT_RESET;
            is_wr_reg <= 1'b0;
            mode_reg <= HPWG_MODE_DUMMY_ADDR;
            taddr_reg <= '0;
            bus.cs_n <= 1'b1;
            bus.wr_n <= 1'b1;
            bus.rd_n <= 1'b1;
            bus.addr <= STATUS_FLAGS_ADDR;
            bus.data_h2d <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_rdata <= '0;
        end
        else
        begin
            o_done <= 1'b0;
            if (!cnt_done)
                cnt_reg <= cnt_reg - 4'h1;
            unique case (state_reg)
                HS_IDLE:
                    if (i_req)
                    begin
                        mode_reg <= i_mode_envelope ? HPWG_MODE_ENVELOPE
                            : HPWG_MODE_DUMMY_ADDR;
                        is_wr_reg <= i_req_write;
                        taddr_reg <= i_req_addr;
                        bus.data_h2d <= i_req_data;
                        o_busy <= 1'b1;
                        if (i_mode_envelope)
                        begin
                            bus.addr <= i_req_addr;
                            bus.wr_n <= 1'b0;
                        end
                        else
                            bus.addr <= DUMMY_ADDR;
                        cnt_reg <= 4'(SETUP_CYCLES);
                        state_reg <= HS_PRESET;
                    end
                HS_PRESET:
                    if (cnt_done)
                    begin
                        bus.cs_n <= 1'b0;
                        cnt_reg <= 4'(SETTLE_CYCLES);
                        state_reg <= HS_SELECT;
                    end
                HS_SELECT:
                    if (cnt_done)
                    begin
                        bus.addr <= taddr_reg;
                        if (mode_reg == HPWG_MODE_DUMMY_ADDR)
                        begin
                            bus.wr_n <= ~is_wr_reg;
                            bus.rd_n <= is_wr_reg;
                        end
                        else if (!is_wr_reg)
                            bus.rd_n <= 1'b0;
                        cnt_reg <= 4'(STROBE_CYCLES);
                        state_reg <= HS_STROBE;
                    end
                HS_STROBE:
                    if (cnt_done)
                    begin
                        // reads leave wr alone: lifting it under cs would commit a write
                        if (is_wr_reg)
                            bus.wr_n <= 1'b1;
                        bus.rd_n <= 1'b1;
                        if (!is_wr_reg)
                            o_rdata <= bus.data_d2h;
                        cnt_reg <= 4'(SETUP_CYCLES);
                        state_reg <= HS_RELEASE;
                    end
                HS_RELEASE:
                    if (cnt_done)
                    begin
                        bus.cs_n <= 1'b1;
                        cnt_reg <= 4'(SETUP_CYCLES);
                        state_reg <= HS_SETTLE;
                    end
                HS_SETTLE:
                    if (cnt_done)
                    begin
                        bus.addr <= STATUS_FLAGS_ADDR;
                        // enveloped read ends here, after cs is already high
                        bus.wr_n <= 1'b1;
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                        state_reg <= HS_IDLE;
                    end
            endcase
        end
    end
endmodule : hpwg_host

// ### hpwg_pkg.sv
// package: constants for the host port write guard
package hpwg_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam logic [6:0] STATUS_FLAGS_ADDR = 7'h16;
    localparam logic [6:0] DUMMY_ADDR = 7'h7F;
    localparam logic [15:0] STATUS_FLAGS_RESET = 16'h0000;
    localparam int NUM_REGS = 128;
    localparam logic [6:0] USED_REG_LIMIT = 7'h20;
    localparam int SETUP_CYCLES = 2;
    localparam int STROBE_CYCLES = 3;
    localparam int SETTLE_CYCLES = 2;
    localparam logic [3:0] WAIT_RESET = 4'h0;
    typedef enum logic {
        HPWG_MODE_DUMMY_ADDR,
        HPWG_MODE_ENVELOPE
    } hpwg_mode_type;
endpackage : hpwg_pkg

// ### hpwg_properties.sv
// checker: host port pin properties
`timescale 1ns/1ps
module hpwg_properties
    import hpwg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic [6:0] addr,
    input wire logic data_d2h_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // read seen inside the current select; cleared once cs lifts
    logic rd_seen_reg;
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || cs_n)
            rd_seen_reg <= 1'b0;
        else if (!rd_n)
            rd_seen_reg <= 1'b1;
    end
    // ====================
    // sequences
    sequence s_sel_wr_high;
        $fell(cs_n) && wr_n;
    endsequence
    sequence s_strobe;
        !wr_n[*2];
    endsequence
    // ====================
    // properties
    property p_safe_addr;
        $fell(cs_n) |-> !wr_n || addr == STATUS_FLAGS_ADDR || addr >= USED_REG_LIMIT;
    endproperty
    property p_addr_hold;
        s_sel_wr_high |=> $stable(addr);
    endproperty
    property p_rd_sel;
        !rd_n |-> !cs_n;
    endproperty
    property p_oe_sel;
        $rose(data_d2h_oe) |-> !cs_n;
    endproperty
    property p_wr_rise_sel;
        $rose(wr_n) |-> !cs_n || $past(cs_n);
    endproperty
    property p_release;
        $rose(cs_n) |-> rd_n && $stable(wr_n);
    endproperty
    property p_rd_no_wr;
        rd_seen_reg && !cs_n |-> !$rose(wr_n);
    endproperty
    property p_idle_addr;
        $rose(cs_n) |-> ##[1:4] addr == STATUS_FLAGS_ADDR;
    endproperty
    property p_strobe;
        $fell(wr_n) && !cs_n |-> s_strobe;
    endproperty
    property p_envelope;
        $fell(wr_n) && cs_n |-> ##[1:6] !cs_n;
    endproperty
    a_safe_addr: assert property (p_safe_addr) else $error("unsafe address at select");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved at select");
    a_rd_sel: assert property (p_rd_sel) else $error("read outside select");
    a_oe_sel: assert property (p_oe_sel) else $error("data driven unselected");
    a_wr_rise_sel: assert property (p_wr_rise_sel) else $error("write edge unselected");
    a_release: assert property (p_release) else $error("strobe moved at release");
    a_rd_no_wr: assert property (p_rd_no_wr) else $error("write edge inside read");
    a_idle_addr: assert property (p_idle_addr) else $error("idle address missing");
    a_strobe: assert property (p_strobe) else $error("write strobe too short");
    a_envelope: assert property (p_envelope) else $error("select not enveloped");
endmodule : hpwg_properties

// ### tb.sv
// testbench: host and device ends, plus a hand-driven second port
`timescale 1ns/1ps
module tb;
    import hpwg_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic mode = 1'b0;
    logic req = 1'b0;
    logic req_wr = 1'b0;
    logic [6:0] req_addr = 7'h00;
    logic [15:0] req_data = 16'h0000;
    logic [15:0] set_a = 16'h0000;
    logic [15:0] set_b = 16'h0000;
    logic busy, done, pls_a, pls_b;
    logic [15:0] rdata, flg_a, flg_b, wd_a, wd_b;
    logic [6:0] wa_a, wa_b;
    int err_total = 0;
    int total_checks = 0;
    int np = 0;
    int na = 0;
    hpwg_bus_if bus();
    hpwg_bus_if bus_b();
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk)
        if (pls_b) np++;
    always @(posedge i_clk)
        if (pls_a) na++;
    hpwg_host i_hpwg_host (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus),
        .i_mode_envelope(mode), .i_req(req), .i_req_write(req_wr), .i_req_addr(req_addr),
        .i_req_data(req_data), .o_busy(busy), .o_done(done), .o_rdata(rdata));
    hpwg_device i_hpwg_device (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus),
        .i_status_set(set_a), .o_status_flags(flg_a), .o_internal_write_pulse(pls_a),
        .o_write_addr(wa_a), .o_write_data(wd_a));
    // second device: its pins are driven by the bench to break host rules
    hpwg_device i_hpwg_device_b (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus_b),
        .i_status_set(set_b), .o_status_flags(flg_b), .o_internal_write_pulse(pls_b),
        .o_write_addr(wa_b), .o_write_data(wd_b));
    hpwg_properties i_hpwg_properties (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .cs_n(bus.cs_n), .wr_n(bus.wr_n), .rd_n(bus.rd_n), .addr(bus.addr),
        .data_d2h_oe(bus.data_d2h_oe));
    // ====================
    // tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    task automatic acc(input logic m, input logic w, input logic [6:0] a, input logic [15:0] d);
        @(negedge i_clk);
        mode = m;
        req_wr = w;
        req_addr = a;
        req_data = d;
        req = 1'b1;
        @(negedge i_clk);
        req = 1'b0;
        chk({15'h0000, busy}, 16'h0001);
        repeat (40)
        begin
            @(posedge i_clk);
            #1;
            if (done === 1'b1) break;
        end
        chk({15'h0000, done}, 16'h0001);
        chk({15'h0000, busy}, 16'h0000);
        repeat (8) @(negedge i_clk);
    endtask : acc
    task automatic pins(input logic cs, input logic wr, input logic [6:0] a, input logic [15:0] d);
        @(negedge i_clk);
        bus_b.addr = a;
        bus_b.data_h2d = d;
        bus_b.cs_n = cs;
        bus_b.wr_n = wr;
        repeat (7) @(negedge i_clk);
    endtask : pins
    task automatic s_host;
        acc(1'b0, 1'b1, 7'h03, 16'h1234);
        chk({9'h000, wa_a}, 16'h0003);
        chk(wd_a, 16'h1234);
        acc(1'b1, 1'b1, 7'h04, 16'ha5a5);
        chk(wd_a, 16'ha5a5);
        acc(1'b1, 1'b0, 7'h03, 16'h0000);
        chk(rdata, 16'h1234);
        chk(na[15:0], 16'h0002);
        acc(1'b0, 1'b0, 7'h04, 16'h0000);
        chk(rdata, 16'ha5a5);
        chk(na[15:0], 16'h0003);
        chk({9'h000, wa_a}, {9'h000, DUMMY_ADDR});
        acc(1'b0, 1'b0, 7'h03, 16'h0000);
        chk(rdata, 16'h1234);
        set_a = 16'h0f00;
        @(negedge i_clk);
        set_a = 16'h0000;
        repeat (3) @(negedge i_clk);
        chk(flg_a, 16'h0f00);
        acc(1'b0, 1'b1, STATUS_FLAGS_ADDR, 16'h0000);
        chk(flg_a, 16'h0000);
    endtask : s_host
    task automatic s_spurious;
        pins(1'b0, 1'b0, 7'h02, 16'h1111);
        pins(1'b0, 1'b1, 7'h02, 16'h1111);
        chk(wd_b, 16'h1111);
        pins(1'b1, 1'b1, 7'h02, 16'h1111);
        np = 0;
        // unarmed select with strobe high must stay quiet
        pins(1'b0, 1'b1, 7'h05, 16'h2222);
        pins(1'b1, 1'b1, 7'h05, 16'h2222);
        chk(np[15:0], 16'h0000);
        pins(1'b1, 1'b0, 7'h05, 16'hbeef);
        pins(1'b1, 1'b1, 7'h05, 16'hbeef);
        pins(1'b0, 1'b1, 7'h05, 16'hbeef);
        chk(np[15:0], 16'h0001);
        chk({9'h000, wa_b}, 16'h0005);
        chk(wd_b, 16'hbeef);
        pins(1'b1, 1'b1, 7'h05, 16'hbeef);
        set_b = 16'hffff;
        pins(1'b1, 1'b0, STATUS_FLAGS_ADDR, 16'h0000);
        set_b = 16'h0000;
        chk(flg_b, 16'hffff);
        pins(1'b1, 1'b1, STATUS_FLAGS_ADDR, 16'h0000);
        pins(1'b0, 1'b1, STATUS_FLAGS_ADDR, 16'h0000);
        chk(flg_b, 16'h0000);
    endtask : s_spurious
    // ====================
    // run
    initial
    begin
        bus_b.cs_n = 1'b1;
        bus_b.wr_n = 1'b1;
        bus_b.rd_n = 1'b1;
        bus_b.addr = STATUS_FLAGS_ADDR;
        bus_b.data_h2d = 16'h0000;
        repeat (12) @(negedge i_clk);
        i_sys_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        chk(flg_a, STATUS_FLAGS_RESET);
        s_host();
        s_spurious();
        tally_and_finish();
    end
    // run needs about 270 cycles
    initial
    begin
        #100000;
        err_total++;
        tally_and_finish();
    end
endmodule : tb
